// ### rcr_pkg.sv
package rcr_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Word and register layout
  localparam int          WORD_BITS      = 14;
  localparam int          REG_W          = 12;
  localparam int          BIT_CNT_W      = 4;
  localparam logic [3:0]  LAST_BIT       = 4'hd;
  localparam logic [3:0]  FIRST_BIT      = 4'h0;
  localparam int          CMD_POS        = 13;
  localparam int          ADDR_POS       = 12;
  localparam logic        CMD_OFF        = 1'b1;
  localparam logic        ADDR_MODE      = 1'b1;

  typedef struct packed {
    logic [1:0] baud_range_code;
    logic [1:0] bit_check_count_code;
    logic       port_level_bit;
    logic [4:0] sleep;
    logic       standard_sleep_extension;
    logic       temporary_sleep_extension;
  } rcr_mode_t;

  typedef struct packed {
    logic [5:0] lim_min;
    logic [5:0] lim_max;
  } rcr_limit_t;

  typedef struct packed {
    logic [3:0]  limit_scale_factor;
    logic [3:0]  bit_check_count;
    logic [3:0]  sleep_extension_factor;
    logic [8:0]  lower_limit_cyc;
    logic [8:0]  upper_limit_cyc;
    logic [17:0] sleep_cyc;
  } rcr_timing_t;

  typedef enum logic {ST_IDLE, ST_BITS} rcr_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and field codes
  localparam rcr_mode_t  MODE_RST       = 12'h22c;
  localparam rcr_limit_t LIMIT_RST      = 12'h398;
  localparam logic [3:0] SCALE_BASE     = 4'h8;
  localparam logic [3:0] SLEEP_EXTENSION_FACTOR_ONE     = 4'h1;
  localparam logic [3:0] SLEEP_EXTENSION_FACTOR_EXT     = 4'h8;
  localparam logic [4:0] SLEEP_CONT     = 5'h00;
  localparam logic [4:0] SLEEP_PERM     = 5'h1f;
  localparam logic [5:0] LIM_ONE        = 6'h01;
  localparam logic [9:0] SLEEP_UNIT_LSB = 10'h000;
  localparam logic [3:0] BITCHK_N0      = 4'h0;
  localparam logic [3:0] BITCHK_N1      = 4'h3;
  localparam logic [3:0] BITCHK_N2      = 4'h6;
  localparam logic [3:0] BITCHK_N3      = 4'h9;

  //////////////////////////////////////////////////////////////////////////
  // Pin timing
  localparam int CLK_MHZ          = 250;
  localparam int START_LOW_NS     = 100000;
  localparam int ONE_LOW_NS       = 20000;
  localparam int RM_HALF_NS       = 2000000;
  localparam int START_LOW_DEF    = (START_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int ONE_LOW_DEF      = (ONE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RM_HALF_DEF      = (RM_HALF_NS * CLK_MHZ) / 1000;

endpackage : rcr_pkg

// ### rcr_low_meter.sv
module rcr_low_meter #(
  parameter int MAX_CNT = 25000,
  parameter int LEN_W   = $clog2(MAX_CNT + 1)
)(
  // Clock, reset, enable
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  // Line
  input  wire logic             low_i,
  // Result
  output logic                  done_o,
  output logic [LEN_W-1:0]      len_o
);

  if (MAX_CNT < 1 || LEN_W < $clog2(MAX_CNT + 1))
  begin : g_bad_len
    $error("rcr_low_meter: length width too small for MAX_CNT");
  end

  logic             low_q;
  logic [LEN_W-1:0] cnt;
  wire              at_max = (cnt == LEN_W'(MAX_CNT));

  // Saturating count keeps a very long low from wrapping into a short one
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      low_q  <= 1'b0;
      cnt    <= '0;
      done_o <= 1'b0;
      len_o  <= '0;
    end
    else if (ce_i)
    begin
      low_q  <= low_i;
      done_o <= low_q & ~low_i;
      if (low_q & ~low_i)
        len_o <= cnt;
      if (!low_i)
        cnt <= '0;
      else if (!at_max)
        cnt <= cnt + LEN_W'(1);
    end
  end

endmodule : rcr_low_meter

// ### rcr_config_regs.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module rcr_config_regs
  import rcr_pkg::*;
#(
  parameter int START_LOW_CYC = START_LOW_DEF,
  parameter int ONE_LOW_CYC   = ONE_LOW_DEF,
  parameter int RM_HALF_CYC   = RM_HALF_DEF
)(
  // Clock, reset, enable
  input  wire logic  mclk_i,
  input  wire logic  srst_i,
  input  wire logic  ce_i,
  // One-wire data pin
  input  wire logic  dat_i,
  output logic       dat_o,
  output logic       dat_oe_n_o,
  // Bit check engine
  input  wire logic  bit_check_fail_i,
  // Configuration
  output rcr_mode_t   operating_mode_o,
  output rcr_limit_t  bit_check_limits_o,
  output rcr_timing_t timing_o,
  // Status and pins
  output logic       multipurpose_output_pin_o,
  output logic       off_cmd_o,
  output logic       continuous_poll_o,
  output logic       permanent_sleep_o,
  output logic       reset_marker_active_o
);

  localparam int LEN_W = $clog2(START_LOW_CYC + 1);
  localparam int RM_W  = $clog2(RM_HALF_CYC + 1);

  // Short lows must stay distinguishable from a start pulse
  if (ONE_LOW_CYC < 1 || ONE_LOW_CYC >= START_LOW_CYC || RM_HALF_CYC < 1)
  begin : g_bad_timing
    $error("rcr_config_regs: pulse timing parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  // State
  rcr_mode_t              operating_mode;
  rcr_limit_t             bit_check_limits;
  rcr_timing_t            timing;
  rcr_state_t             state;
  logic [WORD_BITS-1:0]   shreg;
  logic [BIT_CNT_W-1:0]   bit_cnt;
  logic                   temp_ext_live;
  logic                   rm_active;
  logic                   rm_phase;
  logic [RM_W-1:0]        rm_cnt;
  logic                   drive_low;
  logic                   off_cmd;
  logic                   pulse_done;
  logic [LEN_W-1:0]       pulse_len;

  //////////////////////////////////////////////////////////////////////////
  // Pulse decode
  // Only lows made by the controller count, never our own marker lows
  wire                    ext_low   = ~dat_i & ~drive_low;
  wire                    is_start  = pulse_len >= LEN_W'(START_LOW_CYC);
  wire                    bit_val   = pulse_len >= LEN_W'(ONE_LOW_CYC);
  wire                    in_bits   = (state == ST_BITS);
  wire                    got_start = pulse_done & is_start;
  wire                    got_bit   = pulse_done & ~is_start & in_bits;
  wire [WORD_BITS-1:0]    next_word = {shreg[WORD_BITS-2:0], bit_val};
  wire                    first_bit = (bit_cnt == FIRST_BIT);
  wire                    last_bit  = (bit_cnt == LAST_BIT);
  wire                    take_off  = got_bit & first_bit
                                    & (bit_val == CMD_OFF);
  wire                    word_end  = got_bit & last_bit;
  wire                    wr_mode   = word_end
                          & (next_word[ADDR_POS] == ADDR_MODE);
  wire                    wr_limit  = word_end
                          & (next_word[ADDR_POS] != ADDR_MODE);
  wire rcr_mode_t         new_mode  = rcr_mode_t'(next_word[REG_W-1:0]);
  wire rcr_limit_t        new_limit = rcr_limit_t'(next_word[REG_W-1:0]);

  rcr_low_meter #(
    .MAX_CNT (START_LOW_CYC),
    .LEN_W   (LEN_W)
  ) u_meter (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .low_i   (ext_low),
    .done_o  (pulse_done),
    .len_o   (pulse_len)
  );

  //////////////////////////////////////////////////////////////////////////
  // Word receiver
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state   <= ST_IDLE;
      shreg   <= '0;
      bit_cnt <= '0;
      off_cmd <= 1'b0;
    end
    else if (ce_i)
    begin
      off_cmd <= take_off;
      if (got_start)
      begin
        state   <= ST_BITS;
        bit_cnt <= '0;
      end
      else if (got_bit)
      begin
        shreg   <= next_word;
        bit_cnt <= bit_cnt + BIT_CNT_W'(1);
        if (take_off || last_bit)
          state <= ST_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers
  // The extension write wins over a bit check fail in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      operating_mode   <= MODE_RST;
      bit_check_limits <= LIMIT_RST;
      temp_ext_live    <= MODE_RST.temporary_sleep_extension;
    end
    else if (ce_i)
    begin
      if (wr_mode)
        operating_mode <= new_mode;
      if (wr_limit)
        bit_check_limits <= new_limit;
      if (wr_mode)
        temp_ext_live <= new_mode.temporary_sleep_extension;
      else if (bit_check_fail_i)
        temp_ext_live <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Derived timing
  wire [3:0]  next_scale = SCALE_BASE
                         >> operating_mode.baud_range_code;
  wire [3:0]  next_xs    = (operating_mode.standard_sleep_extension
                           | temp_ext_live) ? SLEEP_EXTENSION_FACTOR_EXT
                                            : SLEEP_EXTENSION_FACTOR_ONE;
  wire [5:0]  max_m1     = bit_check_limits.lim_max - LIM_ONE;
  wire [9:0]  lower_full = 10'(bit_check_limits.lim_min)
                         * 10'(next_scale);
  wire [9:0]  upper_full = 10'(max_m1) * 10'(next_scale);
  wire [8:0]  slp_units  = 9'(operating_mode.sleep) * 9'(next_xs);
  logic [3:0] next_nbits;

  always_comb
  begin
    unique case (operating_mode.bit_check_count_code)
      2'h0: next_nbits = BITCHK_N0;
      2'h1: next_nbits = BITCHK_N1;
      2'h2: next_nbits = BITCHK_N2;
      2'h3: next_nbits = BITCHK_N3;
    endcase
  end

  // Registered so every output leaves a flop; lags a write by one cycle
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      timing            <= '0;
      continuous_poll_o <= 1'b0;
      permanent_sleep_o <= 1'b0;
    end
    else if (ce_i)
    begin
      timing.limit_scale_factor     <= next_scale;
      timing.bit_check_count        <= next_nbits;
      timing.sleep_extension_factor <= next_xs;
      timing.lower_limit_cyc        <= lower_full[8:0];
      timing.upper_limit_cyc        <= upper_full[8:0];
      timing.sleep_cyc <= {slp_units[7:0], SLEEP_UNIT_LSB};
      continuous_poll_o <= (operating_mode.sleep == SLEEP_CONT);
      permanent_sleep_o <= (operating_mode.sleep == SLEEP_PERM);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset marker on the data pin
  // A start pulse from the controller is the only way to end the marker
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rm_active <= 1'b1;
      rm_phase  <= 1'b0;
      rm_cnt    <= '0;
      drive_low <= 1'b0;
    end
    else if (ce_i)
    begin
      if (got_start)
        rm_active <= 1'b0;
      if (!rm_active || rm_cnt == RM_W'(RM_HALF_CYC - 1))
      begin
        rm_cnt   <= '0;
        rm_phase <= rm_active & ~rm_phase;
      end
      else
        rm_cnt <= rm_cnt + RM_W'(1);
      drive_low <= rm_active & ~got_start & rm_phase;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dat_o                     = 1'b0;
  assign dat_oe_n_o                = ~drive_low;
  assign operating_mode_o          = operating_mode;
  assign bit_check_limits_o        = bit_check_limits;
  assign timing_o                  = timing;
  assign multipurpose_output_pin_o = operating_mode.port_level_bit;
  assign off_cmd_o                 = off_cmd;
  assign reset_marker_active_o     = rm_active;

endmodule : rcr_config_regs

// ### rcr_checker.sv
module rcr_checker
  import rcr_pkg::*;
(
  // Clock and pins
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic        ce_i,
  input wire logic        dat_i,
  input wire logic        dat_o,
  input wire logic        dat_oe_n_o,
  input wire logic        bit_check_fail_i,
  // Configuration and status
  input wire rcr_mode_t   operating_mode_o,
  input wire rcr_limit_t  bit_check_limits_o,
  input wire rcr_timing_t timing_o,
  input wire logic        multipurpose_output_pin_o,
  input wire logic        off_cmd_o,
  input wire logic        continuous_poll_o,
  input wire logic        permanent_sleep_o,
  input wire logic        reset_marker_active_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////
  // Copy of last cycle, since timing_o lags the registers by one
  logic       live;
  rcr_mode_t  m_q;
  rcr_limit_t l_q;
  logic [8:0] sc;
  assign sc = 9'(SCALE_BASE >> m_q.baud_range_code);
  always_ff @(posedge mclk_i)
  begin
    live <= ce_i && !srst_i;
    m_q  <= operating_mode_o;
    l_q  <= bit_check_limits_o;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_dflt;
    $fell(srst_i) |-> operating_mode_o == MODE_RST &&
      bit_check_limits_o == LIMIT_RST && reset_marker_active_o;
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("defaults wrong");
  property p_pin;
    multipurpose_output_pin_o == operating_mode_o.port_level_bit;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin level wrong");
  property p_scale;
    live |-> timing_o.limit_scale_factor == 4'(sc) &&
      timing_o.bit_check_count == 4'(m_q.bit_check_count_code * 3);
  endproperty
  a_scale: assert property (p_scale)
    else $error("scale or count wrong");
  property p_lim;
    live |-> timing_o.lower_limit_cyc == 9'(l_q.lim_min) * sc &&
      timing_o.upper_limit_cyc == 9'(6'(l_q.lim_max - LIM_ONE)) * sc;
  endproperty
  a_lim: assert property (p_lim)
    else $error("limit time wrong");
  property p_slp;
    live |-> timing_o.sleep_cyc == 18'(m_q.sleep) *
      18'(timing_o.sleep_extension_factor) * 18'h400;
  endproperty
  a_slp: assert property (p_slp)
    else $error("sleep time wrong");
  property p_xs;
    live && !m_q.temporary_sleep_extension |->
      timing_o.sleep_extension_factor == (m_q.standard_sleep_extension ?
      SLEEP_EXTENSION_FACTOR_EXT : SLEEP_EXTENSION_FACTOR_ONE);
  endproperty
  a_xs: assert property (p_xs)
    else $error("extension wrong");
  property p_poll;
    live |-> continuous_poll_o == (m_q.sleep == SLEEP_CONT) &&
      permanent_sleep_o == (m_q.sleep == SLEEP_PERM);
  endproperty
  a_poll: assert property (p_poll)
    else $error("poll flags wrong");
  property p_off;
    off_cmd_o |-> $stable(operating_mode_o) &&
      $stable(bit_check_limits_o) ##1 !off_cmd_o;
  endproperty
  a_off: assert property (p_off)
    else $error("off command wrong");
  property p_quiet;
    !reset_marker_active_o && !$past(reset_marker_active_o) |->
      dat_oe_n_o && !dat_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("line driven without marker");
  c_off: cover property (off_cmd_o);
  c_wr: cover property ($changed(operating_mode_o));
  c_rm: cover property ($fell(reset_marker_active_o));
endmodule : rcr_checker

bind rcr_config_regs rcr_checker u_rcr_checker (
  .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .dat_i(dat_i),
  .dat_o(dat_o), .dat_oe_n_o(dat_oe_n_o),
  .bit_check_fail_i(bit_check_fail_i),
  .operating_mode_o(operating_mode_o),
  .bit_check_limits_o(bit_check_limits_o), .timing_o(timing_o),
  .multipurpose_output_pin_o(multipurpose_output_pin_o),
  .off_cmd_o(off_cmd_o), .continuous_poll_o(continuous_poll_o),
  .permanent_sleep_o(permanent_sleep_o),
  .reset_marker_active_o(reset_marker_active_o));

// ### rcr_mcu_model.sv
module rcr_mcu_model #(
  parameter int START_LOW_CYC = 40,
  parameter int ONE_LOW_CYC   = 10
)(
  // Clock and open-drain line
  input  wire logic mclk_i,
  input  wire logic line_i,
  output logic      pull_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pull_n_o = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Low for n cycles, then a random gap to mix prompt and slow timing
  task automatic pulse(input int n);
    int gap;
    gap = 1 + ($urandom % 4);
    repeat (n) @(posedge mclk_i) pull_n_o <= 1'b0;
    @(posedge mclk_i) pull_n_o <= 1'b1;
    repeat (gap) @(posedge mclk_i);
  endtask : pulse
  // Waits for the device to release the line before the start pulse only, or the low is lost
  task automatic send_bits(input logic [13:0] w, input int n);
    #1;
    while (line_i !== 1'b1) @(posedge mclk_i);
    pulse(START_LOW_CYC + ($urandom % 4));
    for (int i = 13; i > 13 - n; i--)
      pulse(w[i] ? ONE_LOW_CYC + ($urandom % 4) :
        1 + ($urandom % (ONE_LOW_CYC - 1)));
  endtask : send_bits
endmodule : rcr_mcu_model

// ### tb.sv
module tb
  import rcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 40;
  localparam int ON = 10;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        fail = 1'b0;
  logic        ce   = 1'b1;
  logic        pull_n, oe_n, dout, pin, offc, cont, perm, mark;
  wire         line;
  rcr_mode_t   mode, exp_mode = MODE_RST;
  rcr_limit_t  lim, exp_lim = LIMIT_RST;
  rcr_timing_t tim;
  bit          failed = 1'b0;
  int          n_mismatch = 0, tests_run = 0, n_off = 0;
  assign line = oe_n & pull_n;
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) if (offc === 1'b1) n_off++;
  rcr_config_regs #(.START_LOW_CYC(ST), .ONE_LOW_CYC(ON), .RM_HALF_CYC(64))
  u_rcr_config_regs (.mclk_i(mclk), .srst_i(srst), .ce_i(ce),
    .dat_i(line), .dat_o(dout), .dat_oe_n_o(oe_n),
    .bit_check_fail_i(fail), .operating_mode_o(mode),
    .bit_check_limits_o(lim), .timing_o(tim),
    .multipurpose_output_pin_o(pin), .off_cmd_o(offc),
    .continuous_poll_o(cont), .permanent_sleep_o(perm),
    .reset_marker_active_o(mark));
  rcr_mcu_model #(.START_LOW_CYC(ST), .ONE_LOW_CYC(ON)) u_rcr_mcu_model (
    .mclk_i(mclk), .line_i(line), .pull_n_o(pull_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [51:0] e,
    input logic [51:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Reference model of registers and derived timing
  task automatic chk_all;
    rcr_timing_t t;
    int sc;
    sc = 8 >> exp_mode.baud_range_code;
    t.limit_scale_factor = 4'(sc);
    t.bit_check_count = 4'(3 * exp_mode.bit_check_count_code);
    t.sleep_extension_factor = (exp_mode.standard_sleep_extension ||
      (exp_mode.temporary_sleep_extension && !failed)) ? 4'h8 : 4'h1;
    t.lower_limit_cyc = 9'(exp_lim.lim_min * sc);
    t.upper_limit_cyc = 9'(((exp_lim.lim_max + 63) % 64) * sc);
    t.sleep_cyc = 18'(exp_mode.sleep * t.sleep_extension_factor * 1024);
    chk("mode", 52'(exp_mode), 52'(mode));
    chk("limit", 52'(exp_lim), 52'(lim));
    chk("pin", 52'(exp_mode.port_level_bit), 52'(pin));
    chk("timing", 52'(t),
      52'(tim));
    chk("poll", 52'({exp_mode.sleep == 0, exp_mode.sleep == 31}),
      52'({cont, perm}));
  endtask : chk_all
  task automatic write(input logic [13:0] w, input int n);
    u_rcr_mcu_model.send_bits(w, n);
    repeat (6) @(posedge mclk);
  endtask : write
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rcr_mode_t  mv;
    rcr_limit_t lv;
    int k;
    void'($urandom(2080));
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_all();
    chk("marker", 52'h1, 52'(mark));
    for (int i = 0; i < 8; i++)
    begin
      mv = 12'($urandom);
      mv.baud_range_code = 2'(i);
      mv.bit_check_count_code = 2'(i + 1);
      mv.port_level_bit = i[1];
      mv.temporary_sleep_extension = i[0];
      if (i == 2) mv.sleep = SLEEP_CONT;
      if (i == 5) mv.sleep = SLEEP_PERM;
      exp_mode = mv;
      failed = 1'b0;
      write({2'b01, mv}, 14);
      chk_all();
      chk("marker", 52'h0, 52'(mark));
      // A fail while the enable is low must not clear the extension
      ce <= 1'b0;
      fail <= 1'b1;
      repeat (3) @(posedge mclk);
      chk_all();
      ce <= 1'b1;
      @(posedge mclk) fail <= 1'b0;
      failed = 1'b1;
      repeat (3) @(posedge mclk);
      chk_all();
      lv = 12'($urandom);
      exp_lim = lv;
      write({2'b00, lv}, 14);
      chk_all();
    end
    for (int i = 0; i < 2; i++)
    begin
      write({1'b1, i[0], 12'hfff}, 2);
      chk("off_count", 52'(i + 1), 52'(n_off));
      chk_all();
    end
    // A fresh start pulse mid-word must drop the partial bits
    u_rcr_mcu_model.send_bits(14'h1fff, 5);
    lv = 12'($urandom);
    exp_lim = lv;
    write({2'b00, lv}, 14);
    chk_all();
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    exp_mode = MODE_RST;
    exp_lim = LIMIT_RST;
    failed = 1'b0;
    repeat (2) @(posedge mclk);
    chk_all();
    k = 0;
    while (oe_n !== 1'b0 && k < 200)
    begin
      @(posedge mclk);
      k++;
    end
    chk("marker_low", 52'h0, 52'(oe_n));
    chk("marker_dat", 52'h0, 52'(dout));
    exp_mode.port_level_bit = 1'b1;
    write({2'b01, exp_mode}, 14);
    chk_all();
    chk("marker", 52'h0, 52'(mark));
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
endmodule : tb
